// ==== rtl/sram_port_map.vh ====
// Constants for the pipelined SRAM port block
`ifndef SRAM_PORT_MAP_VH
`define SRAM_PORT_MAP_VH

// ==========================================
// Array geometry
`define ADDR_W 18
`define DEPTH 262144
`define DATA_W 32
`define LANES 4
`define LANE_W 8
`define WORD_W 36
`define BURST_W 2
`define BURST_ONE 2'h1

// ==========================================
// Write buffer entry and count
`define ENT_W 58
`define ENT_DATA_LSB 0
`define ENT_DATA_MSB 35
`define ENT_BW_LSB 36
`define ENT_BW_MSB 39
`define ENT_ADDR_LSB 40
`define ENT_ADDR_MSB 57
`define CNT_W 2
`define CNT_FULL 2'h2
`define CNT_ONE 2'h1

// ==========================================
// Register offsets
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_WCOUNT 12'h008

// ==========================================
// Field positions and reset values
`define CTRL_HOLD_BIT 0
`define ST_MODE_BIT 0
`define ST_ACTIVE_BIT 1
`define ST_DRIVE_BIT 2
`define ST_OVR_BIT 3
`define ST_CNT_LSB 4
`define ST_CNT_MSB 5
`define MODE_RESET 1'b1
`define ZERO32 32'h0000_0000
`define ONE32 32'h0000_0001

`endif

// ==== rtl/sram_port.v ====
// Pipelined burst SRAM port with write buffer and APB status registers
`timescale 1ns/1ps
`include "sram_port_map.vh"

// Operation
// RQ1: All synchronous inputs sampled on rising edge
// RQ2: Edge acted on only when qualifier low
// RQ3: Qualifier high freezes all state, no deselect; the write buffer still drains into the array while frozen
// RQ4: Selected when first low, second high, third low
// RQ5: Third select active low, sampled with others
// RQ6: Output enable high tristates data and parity
// RQ7: Tristate on write data, after deselect, deselected
// RQ8: Read data from address of previous rise
// RQ9: Write data captured on rising edge
// RQ10: Parity lanes follow data lanes and byte writes
// RQ11: Strap high interleaved, low linear burst
// RQ12: Unconnected strap defaults high, interleaved
// RQ13: Controller keeps strap fixed during operation
// RQ14: Byte write selects gate lane and parity
// RQ15: Advance high steps counter, low loads address
// RQ16: Deselect tristates outputs after next rise
// RQ17: Controller drives pins only in write cycles
module sram_port (
    // Clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // Memory control pins
    input wire clock_qualify_n_i,
    input wire select_low_first_i,
    input wire select_high_second_i,
    input wire select_low_third_i,
    input wire burst_advance_load_i,
    input wire write_en_n_i,
    input wire [`LANES-1:0] byte_lane_write_n_i,
    input wire [`ADDR_W-1:0] addr_i,
    input wire output_en_n_i,
    input wire burst_order_i,
    // Data and parity pins
    input wire [`DATA_W-1:0] data_i,
    output wire [`DATA_W-1:0] data_o,
    output wire data_oe_o,
    input wire [`LANES-1:0] parity_lines_i,
    output wire [`LANES-1:0] parity_lines_o,
    output wire parity_lines_oe_o,
    // Write buffer back-pressure
    output wire write_ready_o,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr
);

    // ==========================================
    // Declarations
    reg [`WORD_W-1:0] mem [0:`DEPTH-1];
    reg mode_r;
    reg strap_taken_r;
    reg op_valid_r;
    reg op_write_r;
    reg [`ADDR_W-1:0] base_addr_r;
    reg [`BURST_W-1:0] burst_cnt_r;
    reg [`LANES-1:0] op_bw_n_r;
    reg drive_r;
    reg [`WORD_W-1:0] dout_r;
    reg [`ENT_W-1:0] buf0_r;
    reg [`ENT_W-1:0] buf1_r;
    reg [`CNT_W-1:0] count_r;
    reg hold_r;
    reg overrun_r;
    reg [31:0] wcount_r;
    wire ce;
    wire selected;
    wire [`BURST_W-1:0] burst_nxt;
    wire [`BURST_W-1:0] low_bits;
    wire [`ADDR_W-1:0] op_addr;
    wire [`WORD_W-1:0] wr_word;
    wire [`ENT_W-1:0] new_ent;
    wire push;
    wire push_ok;
    wire pop;
    wire apb_wr;
    wire apb_rd;
    wire mapped;
    reg [`WORD_W-1:0] fwd_word;
    reg [`ENT_W-1:0] head_ent;
    reg [31:0] status_val;

    // ==========================================
    // Clock qualification and select decode
    assign ce = ~clock_qualify_n_i; // RQ2
    assign selected = ~select_low_first_i & select_high_second_i & ~select_low_third_i; // RQ4 RQ5

    // ==========================================
    // Burst address generation
    assign burst_nxt = burst_cnt_r + `BURST_ONE;
    // Interleaved xors the count, linear adds it
    assign low_bits = mode_r ? (base_addr_r[`BURST_W-1:0] ^ burst_cnt_r) :
                      (base_addr_r[`BURST_W-1:0] + burst_cnt_r); // RQ11
    assign op_addr = {base_addr_r[`ADDR_W-1:`BURST_W], low_bits};

    // ==========================================
    // Burst order strap, caught once after reset release
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_r <= `MODE_RESET; // RQ12
            strap_taken_r <= 1'b0;
        end else if (!strap_taken_r) begin
            mode_r <= burst_order_i; // RQ11
            strap_taken_r <= 1'b1;
        end
    end

    // ==========================================
    // Address and control stage
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_valid_r <= 1'b0;
            op_write_r <= 1'b0;
            base_addr_r <= {`ADDR_W{1'b0}};
            burst_cnt_r <= {`BURST_W{1'b0}};
            op_bw_n_r <= {`LANES{1'b1}};
        end else if (ce) begin // RQ1 RQ3
            if (burst_advance_load_i) begin
                // Continue current operation regardless of selects
                burst_cnt_r <= burst_nxt; // RQ15
                op_bw_n_r <= byte_lane_write_n_i; // RQ14
            end else if (selected) begin
                op_valid_r <= 1'b1;
                op_write_r <= ~write_en_n_i;
                base_addr_r <= addr_i; // RQ15
                burst_cnt_r <= {`BURST_W{1'b0}};
                op_bw_n_r <= byte_lane_write_n_i; // RQ14
            end else begin
                op_valid_r <= 1'b0; // RQ16
            end
        end
    end

    // ==========================================
    // Read forwarding from pending buffered writes
    always @* begin
        fwd_word = mem[op_addr];
        if (count_r != {`CNT_W{1'b0}} && buf0_r[`ENT_ADDR_MSB:`ENT_ADDR_LSB] == op_addr) begin
            fwd_word = merge(fwd_word, buf0_r);
        end
        if (count_r == `CNT_FULL && buf1_r[`ENT_ADDR_MSB:`ENT_ADDR_LSB] == op_addr) begin
            fwd_word = merge(fwd_word, buf1_r);
        end
    end

    // Overlay enabled lanes of a buffer entry onto a word
    function [`WORD_W-1:0] merge;
        input [`WORD_W-1:0] old_w;
        input [`ENT_W-1:0] ent;
        integer k;
        begin
            merge = old_w;
            for (k = 0; k < `LANES; k = k + 1) begin
                if (!ent[`ENT_BW_LSB + k]) begin
                    merge[k*`LANE_W +: `LANE_W] = ent[k*`LANE_W +: `LANE_W];
                    merge[`DATA_W + k] = ent[`DATA_W + k]; // RQ10
                end
            end
        end
    endfunction

    // ==========================================
    // Data stage: output register and drive control
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_r <= 1'b0;
            dout_r <= {`WORD_W{1'b0}};
        end else if (ce) begin // RQ3
            // Drive only for a read; write data cycle and deselect stay off
            drive_r <= op_valid_r & ~op_write_r; // RQ7 RQ16
            if (op_valid_r && !op_write_r) begin
                dout_r <= fwd_word; // RQ8
            end
        end
    end

    assign data_o = dout_r[`DATA_W-1:0];
    assign parity_lines_o = dout_r[`WORD_W-1:`DATA_W]; // RQ10
    assign data_oe_o = drive_r & ~output_en_n_i; // RQ6 RQ7
    assign parity_lines_oe_o = drive_r & ~output_en_n_i; // RQ6 RQ10

    // ==========================================
    // Write capture into the two-entry buffer
    assign wr_word = {parity_lines_i, data_i}; // RQ9 RQ10
    assign new_ent = {op_addr, op_bw_n_r, wr_word};
    assign push = ce & op_valid_r & op_write_r; // RQ9
    assign write_ready_o = (count_r != `CNT_FULL);
    assign pop = (count_r != {`CNT_W{1'b0}}) & ~hold_r;
    assign push_ok = push & (write_ready_o | pop);

    always @* begin
        head_ent = buf0_r;
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            buf0_r <= {`ENT_W{1'b0}};
            buf1_r <= {`ENT_W{1'b0}};
            count_r <= {`CNT_W{1'b0}};
        end else begin
            case ({push_ok, pop})
                2'b10: begin
                    if (count_r == {`CNT_W{1'b0}}) begin
                        buf0_r <= new_ent;
                    end else begin
                        buf1_r <= new_ent;
                    end
                    count_r <= count_r + `CNT_ONE;
                end
                2'b01: begin
                    buf0_r <= buf1_r;
                    count_r <= count_r - `CNT_ONE;
                end
                2'b11: begin
                    if (count_r == `CNT_ONE) begin
                        buf0_r <= new_ent;
                    end else begin
                        buf0_r <= buf1_r;
                        buf1_r <= new_ent;
                    end
                end
                default: begin
                    count_r <= count_r;
                end
            endcase
        end
    end

    // ==========================================
    // Array write port, one lane per generate step
    wire [`ADDR_W-1:0] head_addr;
    wire [`WORD_W-1:0] head_old;
    wire [`WORD_W-1:0] pop_word;

    assign head_addr = head_ent[`ENT_ADDR_MSB:`ENT_ADDR_LSB];
    assign head_old = mem[head_addr];

    // Lanes not selected keep their stored byte and parity bit
    genvar g;
    generate
        for (g = 0; g < `LANES; g = g + 1) begin : lane
            assign pop_word[g*`LANE_W +: `LANE_W] = head_ent[`ENT_BW_LSB + g] ?
                head_old[g*`LANE_W +: `LANE_W] : head_ent[g*`LANE_W +: `LANE_W]; // RQ14
            assign pop_word[`DATA_W + g] = head_ent[`ENT_BW_LSB + g] ?
                head_old[`DATA_W + g] : head_ent[`DATA_W + g]; // RQ10
        end
    endgenerate

    // Single writer keeps the array on one driver
    always @(posedge mclk_i) begin
        if (pop) begin
            mem[head_addr] <= pop_word;
        end
    end

    // ==========================================
    // APB slave
    assign apb_wr = psel & penable & pwrite;
    assign apb_rd = psel & penable & ~pwrite;
    assign mapped = (paddr == `OFF_CTRL) | (paddr == `OFF_STATUS) | (paddr == `OFF_WCOUNT);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always @* begin
        status_val = `ZERO32;
        status_val[`ST_MODE_BIT] = mode_r;
        status_val[`ST_ACTIVE_BIT] = op_valid_r;
        status_val[`ST_DRIVE_BIT] = drive_r;
        status_val[`ST_OVR_BIT] = overrun_r;
        status_val[`ST_CNT_MSB:`ST_CNT_LSB] = count_r;
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_r <= 1'b0;
            overrun_r <= 1'b0;
            wcount_r <= `ZERO32;
            prdata <= `ZERO32;
        end else begin
            if (apb_wr && paddr == `OFF_CTRL) begin
                hold_r <= pwdata[`CTRL_HOLD_BIT];
            end
            // Lost write sets the flag; setting wins over clearing
            if (push && !push_ok) begin
                overrun_r <= 1'b1;
            end else if (apb_wr && paddr == `OFF_STATUS && pwdata[`ST_OVR_BIT]) begin
                overrun_r <= 1'b0;
            end
            if (push_ok) begin
                wcount_r <= wcount_r + `ONE32;
            end else if (apb_wr && paddr == `OFF_WCOUNT) begin
                wcount_r <= `ZERO32;
            end
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `OFF_CTRL: prdata <= {31'h0000_0000, hold_r};
                    `OFF_STATUS: prdata <= status_val;
                    `OFF_WCOUNT: prdata <= wcount_r;
                    default: prdata <= `ZERO32;
                endcase
            end
        end
    end

endmodule // sram_port

// ==== verif/sram_port_sva.sv ====
// Assertions on the SRAM port pins and APB slave
`timescale 1ns/1ps
module sram_port_sva (
    // Clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // Pins
    input wire clock_qualify_n_i,
    input wire select_low_first_i,
    input wire select_high_second_i,
    input wire select_low_third_i,
    input wire burst_advance_load_i,
    input wire write_en_n_i,
    input wire output_en_n_i,
    input wire [31:0] data_o,
    input wire data_oe_o,
    input wire [3:0] parity_lines_o,
    input wire parity_lines_oe_o,
    // APB
    input wire psel,
    input wire penable,
    input wire [11:0] paddr,
    input wire pslverr
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    wire en = !clock_qualify_n_i;
    wire ld = en && !burst_advance_load_i;
    wire sel = !select_low_first_i && select_high_second_i && !select_low_third_i;
    wire hit = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;
    sequence s_rd;
        ld && sel && write_en_n_i ##1 en;
    endsequence
    sequence s_wr;
        ld && sel && !write_en_n_i ##1 en;
    endsequence
    sequence s_off;
        ld && !sel ##1 en;
    endsequence
    oe_mask_a: assert property (output_en_n_i |-> !data_oe_o)
        else $error("pins driven with oe high");
    parity_oe_a: assert property (data_oe_o == parity_lines_oe_o)
        else $error("parity oe differs");
    wr_tristate_a: assert property (s_wr |=> !data_oe_o)
        else $error("driven in write data cycle");
    rd_drive_a: assert property (s_rd |=> data_oe_o == !output_en_n_i)
        else $error("read data not driven");
    desel_off_a: assert property (s_off |=> !data_oe_o)
        else $error("driven after deselect");
    freeze_data_a: assert property (!en |=> $stable({parity_lines_o, data_o}))
        else $error("data moved while frozen");
    freeze_oe_a: assert property (!en ##1 $stable(output_en_n_i) |-> $stable(data_oe_o))
        else $error("oe moved while frozen");
    unmapped_err_a: assert property (psel && penable && !hit |-> pslverr)
        else $error("no error on unmapped");
    mapped_ok_a: assert property (!(psel && penable) || hit |-> !pslverr)
        else $error("spurious error");
endmodule // sram_port_sva

bind sram_port sram_port_sva sram_port_sva_i (.mclk_i, .rst_n_i, .clock_qualify_n_i,
    .select_low_first_i, .select_high_second_i, .select_low_third_i, .burst_advance_load_i,
    .write_en_n_i, .output_en_n_i, .data_o, .data_oe_o, .parity_lines_o, .parity_lines_oe_o,
    .psel, .penable, .paddr, .pslverr);

// ==== verif/host_model.sv ====
// Memory controller model driving the SRAM port pins
`timescale 1ns/1ps
module host_model (
    // Clock and read back pins
    input wire mclk_i,
    input wire [35:0] rd_i,
    input wire roe_i,
    // Driven pins
    output reg cq_n_o = 1'h1,
    output reg [2:0] sel_o = 3'h6,
    output reg adv_o = 1'h0,
    output reg wen_n_o = 1'h1,
    output reg [3:0] bw_n_o = 4'h0,
    output reg [17:0] addr_o = 18'h0,
    output wire [35:0] wd_o
);
    reg drv_r = 1'h0;
    reg [35:0] w_r = 36'h0;
    reg [2:0] selpat = 3'h2;
    reg [36:0] got [0:3];
    // Released bus shows port read data while the port drives, else inverted value, not a stale copy
    assign wd_o = drv_r ? w_r : roe_i ? rd_i : ~w_r;
    task automatic wr(input [17:0] a, input [35:0] w, input [3:0] b);
        @(posedge mclk_i);
        cq_n_o <= 1'h0;
        sel_o <= selpat;
        adv_o <= 1'h0;
        wen_n_o <= 1'h0;
        addr_o <= a;
        bw_n_o <= b;
        @(posedge mclk_i);
        sel_o <= 3'h6;
        wen_n_o <= 1'h1;
        w_r <= w;
        drv_r <= 1'h1;
        @(posedge mclk_i);
        drv_r <= 1'h0;
    endtask
    // ==========================================
    // Burst read, qualifier high for two edges at beat st
    task automatic rd(input [17:0] a, input int n, input int st);
        for (int k = 0; k <= n + 1; k++) begin
            @(posedge mclk_i);
            if (k == st) begin
                cq_n_o <= 1'h1;
                repeat (2) @(posedge mclk_i);
            end
            cq_n_o <= 1'h0;
            sel_o <= (k < n) ? selpat : 3'h6;
            adv_o <= (k > 0 && k < n);
            wen_n_o <= 1'h1;
            addr_o <= a;
            @(negedge mclk_i);
            if (k > 1)
                got[k - 2] = {roe_i, rd_i};
        end
    endtask
endmodule // host_model

// ==== verif/test_sram_port.sv ====
// Self-checking testbench for the pipelined SRAM port
`timescale 1ns/1ps
`include "sram_port_map.vh"
module test_sram_port;
    reg mclk_i = 1'h0;
    reg rst_n_i = 1'h0;
    reg oe_n = 1'h0;
    reg strap = 1'h1;
    reg psel = 1'h0;
    reg penable = 1'h0;
    reg pwrite = 1'h0;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0;
    wire [31:0] prdata, dat;
    wire [3:0] par, bw_n;
    wire pready, pslverr, doe, wrdy, cq_n, adv, wen_n;
    wire [2:0] sel;
    wire [17:0] addr;
    wire [35:0] wd;
    int err_total = 0;
    int total_checks = 0;
    reg [35:0] mem [int];
    reg [2:0] pats [0:3] = '{3'h2, 3'h6, 3'h0, 3'h3};
    reg [31:0] r;
    reg e;
    reg [17:0] a;
    reg [35:0] w;
    reg [3:0] b;
    always #5 mclk_i = ~mclk_i;
    sram_port sram_port_i (.mclk_i, .rst_n_i, .clock_qualify_n_i(cq_n),
        .select_low_first_i(sel[2]), .select_high_second_i(sel[1]),
        .select_low_third_i(sel[0]), .burst_advance_load_i(adv), .write_en_n_i(wen_n),
        .byte_lane_write_n_i(bw_n), .addr_i(addr), .output_en_n_i(oe_n),
        .burst_order_i(strap), .data_i(wd[31:0]), .data_o(dat), .data_oe_o(doe),
        .parity_lines_i(wd[35:32]), .parity_lines_o(par), .parity_lines_oe_o(),
        .write_ready_o(wrdy), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    host_model host_model_i (.mclk_i, .rd_i({par, dat}), .roe_i(doe), .cq_n_o(cq_n),
        .sel_o(sel), .adv_o(adv), .wen_n_o(wen_n), .bw_n_o(bw_n), .addr_o(addr), .wd_o(wd));
    task automatic chk(input string nm, input logic [36:0] seen, input logic [36:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input [11:0] ad, input [31:0] d);
        @(posedge mclk_i);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'h1;
        @(posedge mclk_i);
        while (pready !== 1'h1)
            @(posedge mclk_i);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    function automatic [17:0] baddr(input [17:0] s, input int k, input logic m);
        baddr = {s[17:2], m ? s[1:0] ^ k[1:0] : s[1:0] + k[1:0]};
    endfunction
    function automatic [35:0] merge(input [35:0] o, input [35:0] n, input [3:0] bl);
        for (int j = 0; j < 4; j++)
            if (!bl[j]) begin
                o[j * 8 +: 8] = n[j * 8 +: 8];
                o[32 + j] = n[32 + j];
            end
        merge = o;
    endfunction
    task automatic summarize;
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #300000;
        err_total++;
        summarize();
    end
    initial begin
        r = $urandom(32332);
        for (int m = 1; m >= 0; m--) begin
            @(posedge mclk_i);
            rst_n_i <= 1'h0;
            strap <= m[0];
            repeat (4) @(posedge mclk_i);
            rst_n_i <= 1'h1;
            @(posedge mclk_i);
            apb(0, `OFF_STATUS, 0);
            chk("mode", r[`ST_MODE_BIT], m[0]);
            for (int i = 1; i < 4; i++) begin
                a = 18'($urandom);
                for (int j = 0; j < 4; j++) begin
                    w = {4'($urandom), $urandom};
                    host_model_i.wr({a[17:2], 2'(j)}, w, 4'h0);
                    mem[{a[17:2], 2'(j)}] = w;
                end
                w = {4'($urandom), $urandom};
                b = 4'($urandom);
                host_model_i.wr(a, w, b);
                mem[a] = merge(mem[a], w, b);
                host_model_i.rd(a, 4, i);
                for (int k = 0; k < 4; k++)
                    chk("burst", host_model_i.got[k], {1'h1, mem[baddr(a, k, m[0])]});
            end
            for (int j = 0; j < 4; j++) begin
                @(posedge mclk_i);
                oe_n <= (j == 0);
                host_model_i.selpat = pats[j];
                host_model_i.rd(a, 1, 9);
                chk("tristate", host_model_i.got[0][36], 1'h0);
            end
            @(posedge mclk_i);
            oe_n <= 1'h0;
            host_model_i.selpat = 3'h2;
            apb(1, `OFF_CTRL, 1);
            for (int j = 0; j < 3; j++)
                host_model_i.wr(a ^ 18'(j), 36'(j + 5), 4'h0);
            @(negedge mclk_i);
            chk("ready", wrdy, 1'h0);
            apb(0, `OFF_STATUS, 0);
            chk("full", {r[`ST_OVR_BIT], r[5:4]}, 3'h6);
            apb(1, `OFF_CTRL, 0);
            repeat (3) @(posedge mclk_i);
            apb(1, `OFF_STATUS, 32'h8);
            apb(0, `OFF_STATUS, 0);
            chk("drained", {wrdy, r[`ST_OVR_BIT], r[5:4]}, 4'h8);
            apb(0, `OFF_WCOUNT, 0);
            chk("wcount", r, 32'h11);
            for (int j = 0; j < 3; j++) begin
                if (j < 2)
                    mem[a ^ 18'(j)] = 36'(j + 5);
                host_model_i.rd(a ^ 18'(j), 1, 9);
                chk("held", host_model_i.got[0], {1'h1, mem[a ^ 18'(j)]});
            end
            apb(0, 12'h00c, 0);
            chk("unmapped", {e, r}, 33'h1_0000_0000);
        end
        summarize();
    end
endmodule // test_sram_port
